// *** inc/fmps_pkg.sv ***
// constants, register map and state type for the float-mode pulse sequencer
// assumes a 50 MHz system clock and a 16-bit register write/read port
// Summary of operation
// - precondition time per slot from 5-bit field, bits 12:8 of 0x5E / 0x59
// - 10-bit float period in us: low byte 0x31/0x36, top bits 0x37
// - connect window lasts 5-bit microsecond field, bits 12:8 of 0x30 / 0x35
// - first dump at 8-bit offset; first float = offset - precondition
// - integration lasts 5-bit field bits 15:11; software sets connect plus one
// - integrator start offset in 31.25 ns steps, 11-bit field
// - pulse count per sample from bits 15:8 of 0x31 / 0x36
// - LED mode uses even count of equal pulses, LED lit in one per pair
// - per-position LED firing taken from pattern field in 0x5A bits 15:8
// - add/subtract choices from 0x58, repeated every group of four pulses
// - accumulate all pulses, then exactly one data write of the total
// - slot runs float operation when its LED-select field in 0x14 is zero
// - photodiode floats between connect pulses when float-enable field is three
// - first-pair code two subtracts first pulse and adds second
// - second-pair code one adds third pulse and subtracts fourth
// - float LED choice bits 15:14 of 0x3E / 0x3F: none, LED1, LED2, LED3
package fmps_pkg;
  // timing
  localparam int CLK_PERIOD_PS = 20000;
  localparam int US_PS = 1000000;
  localparam int STEP_PS = 31250;
  localparam int US_CYCLES = US_PS / CLK_PERIOD_PS;
  localparam int TW = 20;
  // register file
  localparam int NREG = 16;
  localparam int AW = 7;
  localparam int IDX_LED_SEL = 0;
  localparam int IDX_A_DUMP = 1;
  localparam int IDX_A_PERCNT = 2;
  localparam int IDX_B_DUMP = 3;
  localparam int IDX_B_PERCNT = 4;
  localparam int IDX_PER_HI = 5;
  localparam int IDX_A_INTEG = 6;
  localparam int IDX_B_INTEG = 7;
  localparam int IDX_A_CHOICE = 8;
  localparam int IDX_B_CHOICE = 9;
  localparam int IDX_A_AFE = 10;
  localparam int IDX_B_AFE = 11;
  localparam int IDX_MATH = 12;
  localparam int IDX_B_FLT = 13;
  localparam int IDX_FIRE = 14;
  localparam int IDX_A_FLT = 15;
  localparam logic [NREG-1:0][AW-1:0] REG_ADDRS = {
    7'h5E, 7'h5A, 7'h59, 7'h58, 7'h45, 7'h43, 7'h3F, 7'h3E,
    7'h3B, 7'h39, 7'h37, 7'h36, 7'h35, 7'h31, 7'h30, 7'h14};
  localparam logic [15:0] REG_RESET = 16'h0000;
  // field positions
  localparam int PRECON_LSB = 8;
  localparam int FLTEN_LSB = 13;
  localparam int PERLO_LSB = 0;
  localparam int PERHI_A_LSB = 0;
  localparam int PERHI_B_LSB = 8;
  localparam int CNT_LSB = 8;
  localparam int CONN_LSB = 8;
  localparam int DUMP_LSB = 0;
  localparam int IW_LSB = 11;
  localparam int IOFF_LSB = 0;
  localparam int CHOICE_LSB = 14;
  localparam int LEDSEL_A_LSB = 0;
  localparam int LEDSEL_B_LSB = 2;
  localparam int MATH12_A_LSB = 1;
  localparam int MATH12_B_LSB = 5;
  localparam int MATH34_A_LSB = 8;
  localparam int MATH34_B_LSB = 10;
  localparam int FIRE_A_LSB = 8;
  localparam int FIRE_B_LSB = 12;
  // field codes
  localparam logic [1:0] FLTEN_ON = 2'h3;
  localparam logic [1:0] LEDSEL_FLOAT = 2'h0;
  localparam logic [1:0] CHOICE_NONE = 2'h0;
  typedef enum logic [2:0] {
    FMPS_IDLE, FMPS_SETUP, FMPS_RUN, FMPS_WAIT_RES, FMPS_WRITE
  } fmps_state_t;
endpackage

// *** design/fmps_pulse_timer.sv ***
// pulse-relative cycle counter for one float pulse
// assumes the caller restarts it at each pulse and stops it at the pulse end
`timescale 1ns/10ps
module fmps_pulse_timer #(
  parameter int TW = fmps_pkg::TW
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // control
  input wire logic restart,
  input wire logic run,
  input wire logic [TW-1:0] end_cyc,
  // status
  output logic [TW-1:0] pos,
  output logic last
);
  typedef struct packed {
    logic [TW-1:0] pos;
  } fmps_tmr_t;
  fmps_tmr_t cur;
  fmps_tmr_t next_cur;

  // restart wins so a new pulse never inherits the old count
  always_comb begin
    next_cur = cur;
    if (restart) begin
      next_cur.pos = '0;
    end else if (run) begin
      next_cur.pos = cur.pos + TW'(1);
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign pos = cur.pos;
  assign last = run && (cur.pos + TW'(1) >= end_cyc);
endmodule

// *** design/fmps_accumulator.sv ***
// signed add/subtract accumulator for pulse results
// assumes one result per enable; clear has priority over accumulate
`timescale 1ns/10ps
module fmps_accumulator #(
  parameter int RW = 14,
  parameter int ACC_W = 27
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // control
  input wire logic clr,
  input wire logic en,
  input wire logic sub,
  input wire logic [RW-1:0] din,
  // running total
  output logic [ACC_W-1:0] acc
);
  typedef struct packed {
    logic [ACC_W-1:0] acc;
  } fmps_acc_t;
  fmps_acc_t cur;
  fmps_acc_t next_cur;
  logic [ACC_W-1:0] ext;

  // wraps silently on overflow; width sized for a full sample period
  always_comb begin
    next_cur = cur;
    ext = {{(ACC_W-RW){1'b0}}, din};
    if (clr) begin
      next_cur.acc = '0;
    end else if (en) begin
      next_cur.acc = sub ? cur.acc - ext : cur.acc + ext;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign acc = cur.acc;
endmodule

// *** design/fmps_sequencer.sv ***
// float-mode pulse sequencer: register file, slot A/B timing, LED firing,
// add/subtract accumulation and one data write per float-mode slot with a nonzero pulse count per sample period
// assumes register port and ADC result strobe are synchronous to mclk
`timescale 1ns/10ps
module fmps_sequencer #(
  parameter int RW = 14,
  parameter int ACC_W = 27
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [fmps_pkg::AW-1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  // sample control
  input wire logic sample_start,
  output logic busy,
  // front end timing
  output logic precondition_on,
  output logic float_on,
  output logic connect_on,
  output logic integrate_on,
  output logic [2:0] led_drive,
  output logic active_slot,
  // pulse results from the integrator path
  input wire logic result_valid,
  input wire logic [RW-1:0] result,
  // data or fifo write
  output logic data_wr,
  output logic data_slot,
  output logic [ACC_W-1:0] data_value
);
  localparam int TW = fmps_pkg::TW;

  typedef struct packed {
    logic [fmps_pkg::NREG-1:0][15:0] rf;
    logic [15:0] rdata;
    fmps_pkg::fmps_state_t st;
    logic slot;
    logic first;
    logic [7:0] pnum;
    logic [7:0] pulses;
    logic [TW-1:0] precon_c;
    logic [TW-1:0] dump_c;
    logic [TW-1:0] conn_c;
    logic [TW-1:0] integ_at;
    logic [TW-1:0] integ_c;
    logic [TW-1:0] end_c;
    logic [TW-1:0] lead;
    logic pre;
    logic flt;
    logic con;
    logic integ;
    logic [2:0] led;
    logic wr;
    logic wslot;
    logic [ACC_W-1:0] wval;
    logic bsy;
  } fmps_seq_t;

  fmps_seq_t cur;
  fmps_seq_t next_cur;

  // microseconds to clock cycles
  function automatic logic [TW-1:0] us2c(input logic [9:0] us);
    us2c = TW'(int'(us) * fmps_pkg::US_CYCLES);
  endfunction

  // 31.25 ns steps to cycles, rounded down
  function automatic logic [TW-1:0] step2c(input logic [10:0] st);
    step2c = TW'((int'(st) * fmps_pkg::STEP_PS) / fmps_pkg::CLK_PERIOD_PS);
  endfunction

  // per-slot field fetch
  logic [15:0] r_dump;
  logic [15:0] r_percnt;
  logic [15:0] r_integ;
  logic [15:0] r_flt;
  logic [15:0] r_choice;
  logic [9:0] period_us;
  logic [1:0] led_sel;
  logic [1:0] flt_en;
  logic [3:0] fire_pat;
  logic [1:0] math12;
  logic [1:0] math34;
  logic [1:0] choice;
  logic float_mode;

  always_comb begin
    r_dump = cur.slot ? cur.rf[fmps_pkg::IDX_B_DUMP] : cur.rf[fmps_pkg::IDX_A_DUMP];
    r_percnt = cur.slot ? cur.rf[fmps_pkg::IDX_B_PERCNT] : cur.rf[fmps_pkg::IDX_A_PERCNT];
    r_integ = cur.slot ? cur.rf[fmps_pkg::IDX_B_INTEG] : cur.rf[fmps_pkg::IDX_A_INTEG];
    r_flt = cur.slot ? cur.rf[fmps_pkg::IDX_B_FLT] : cur.rf[fmps_pkg::IDX_A_FLT];
    r_choice = cur.slot ? cur.rf[fmps_pkg::IDX_B_CHOICE] : cur.rf[fmps_pkg::IDX_A_CHOICE];
    // upper period bits sit in a shared register
    period_us = {cur.rf[fmps_pkg::IDX_PER_HI][(cur.slot ? fmps_pkg::PERHI_B_LSB
                  : fmps_pkg::PERHI_A_LSB) +: 2], r_percnt[fmps_pkg::PERLO_LSB +: 8]};
    led_sel = cur.rf[fmps_pkg::IDX_LED_SEL][(cur.slot ? fmps_pkg::LEDSEL_B_LSB
                : fmps_pkg::LEDSEL_A_LSB) +: 2];
    flt_en = r_flt[fmps_pkg::FLTEN_LSB +: 2];
    fire_pat = cur.rf[fmps_pkg::IDX_FIRE][(cur.slot ? fmps_pkg::FIRE_B_LSB
                 : fmps_pkg::FIRE_A_LSB) +: 4];
    math12 = cur.rf[fmps_pkg::IDX_MATH][(cur.slot ? fmps_pkg::MATH12_B_LSB
               : fmps_pkg::MATH12_A_LSB) +: 2];
    math34 = cur.rf[fmps_pkg::IDX_MATH][(cur.slot ? fmps_pkg::MATH34_B_LSB
               : fmps_pkg::MATH34_A_LSB) +: 2];
    choice = r_choice[fmps_pkg::CHOICE_LSB +: 2];
    // slot floats only with no LED source and float enabled
    float_mode = (led_sel == fmps_pkg::LEDSEL_FLOAT)
                 && (flt_en == fmps_pkg::FLTEN_ON);
  end

  // register lookup
  logic hit;
  logic [3:0] hit_idx;
  always_comb begin
    hit = 1'b0;
    hit_idx = '0;
    for (int i = 0; i < fmps_pkg::NREG; i++) begin
      if (reg_addr == fmps_pkg::REG_ADDRS[i]) begin
        hit = 1'b1;
        hit_idx = 4'(i);
      end
    end
  end

  // submodules
  logic [TW-1:0] pos;
  logic last;
  logic tmr_restart;
  logic tmr_run;
  logic acc_clr;
  logic acc_en;
  logic acc_sub;
  logic [ACC_W-1:0] acc;
  logic [1:0] grp_pos;

  assign grp_pos = cur.pnum[1:0];
  assign tmr_run = (cur.st == fmps_pkg::FMPS_RUN);
  assign tmr_restart = (cur.st == fmps_pkg::FMPS_SETUP)
                       || (cur.st == fmps_pkg::FMPS_WAIT_RES);
  assign acc_clr = (cur.st == fmps_pkg::FMPS_SETUP);
  assign acc_en = (cur.st == fmps_pkg::FMPS_WAIT_RES) && result_valid;
  // bit 1 subtracts first of the pair, bit 0 the second; the pair pattern
  // repeats every four pulses
  assign acc_sub = grp_pos[1] ? math34[grp_pos[0] ? 0 : 1]
                              : math12[grp_pos[0] ? 0 : 1];

  fmps_pulse_timer #(.TW(TW)) u_timer (
    .mclk(mclk),
    .rst(rst),
    .restart(tmr_restart),
    .run(tmr_run),
    .end_cyc(cur.end_c),
    .pos(pos),
    .last(last)
  );

  fmps_accumulator #(.RW(RW), .ACC_W(ACC_W)) u_acc (
    .mclk(mclk),
    .rst(rst),
    .clr(acc_clr),
    .en(acc_en),
    .sub(acc_sub),
    .din(result),
    .acc(acc)
  );

  // next pulse timing for pulses after the first
  logic [TW-1:0] nxt_dump;
  logic [TW-1:0] nxt_integ_at;
  logic [TW-1:0] dump0;
  logic [TW-1:0] ioff0;
  logic [TW-1:0] integ0_end;
  logic [TW-1:0] conn0_end;
  logic [TW-1:0] nxt_integ_end;
  logic [TW-1:0] nxt_conn_end;
  always_comb begin
    dump0 = us2c({2'h0, r_dump[fmps_pkg::DUMP_LSB +: 8]});
    ioff0 = step2c(r_integ[fmps_pkg::IOFF_LSB +: 11]);
    integ0_end = ioff0 + us2c({5'h00, r_integ[fmps_pkg::IW_LSB +: 5]});
    conn0_end = dump0 + us2c({5'h00, r_dump[fmps_pkg::CONN_LSB +: 5]});
    // later pulses keep the integrator lead relative to the dump
    nxt_dump = us2c(period_us);
    nxt_integ_at = (nxt_dump > cur.lead) ? nxt_dump - cur.lead : '0;
    nxt_integ_end = nxt_integ_at + cur.integ_c;
    nxt_conn_end = nxt_dump + cur.conn_c;
  end

  // sequencer
  always_comb begin
    next_cur = cur;
    next_cur.wr = 1'b0;
    next_cur.pre = 1'b0;
    next_cur.flt = 1'b0;
    next_cur.con = 1'b0;
    next_cur.integ = 1'b0;
    next_cur.led = '0;
    if (reg_wr && hit) begin
      next_cur.rf[hit_idx] = reg_wdata;
    end
    if (reg_rd) begin
      next_cur.rdata = hit ? cur.rf[hit_idx] : '0;
    end
    unique case (cur.st)
      fmps_pkg::FMPS_IDLE: begin
        if (sample_start) begin
          next_cur.slot = 1'b0;
          next_cur.st = fmps_pkg::FMPS_SETUP;
        end
      end
      fmps_pkg::FMPS_SETUP: begin
        next_cur.pulses = r_percnt[fmps_pkg::CNT_LSB +: 8];
        next_cur.precon_c = us2c({5'h00, r_flt[fmps_pkg::PRECON_LSB +: 5]});
        next_cur.conn_c = us2c({5'h00, r_dump[fmps_pkg::CONN_LSB +: 5]});
        next_cur.integ_c = us2c({5'h00, r_integ[fmps_pkg::IW_LSB +: 5]});
        next_cur.dump_c = dump0;
        next_cur.integ_at = ioff0;
        next_cur.lead = (dump0 > ioff0) ? dump0 - ioff0 : '0;
        next_cur.end_c = (integ0_end > conn0_end) ? integ0_end : conn0_end;
        next_cur.first = 1'b1;
        next_cur.pnum = '0;
        if (float_mode && (r_percnt[fmps_pkg::CNT_LSB +: 8] != 8'h00)) begin
          next_cur.st = fmps_pkg::FMPS_RUN;
        end else if (!cur.slot) begin
          next_cur.slot = 1'b1;
        end else begin
          next_cur.st = fmps_pkg::FMPS_IDLE;
        end
      end
      fmps_pkg::FMPS_RUN: begin
        // windows relative to pulse start; first pulse opens with precondition
        next_cur.pre = cur.first && (pos < cur.precon_c);
        next_cur.flt = (pos >= (cur.first ? cur.precon_c : '0))
                       && (pos < cur.dump_c);
        next_cur.con = (pos >= cur.dump_c)
                       && (pos < cur.dump_c + cur.conn_c);
        next_cur.integ = (pos >= cur.integ_at)
                         && (pos < cur.integ_at + cur.integ_c);
        // LED lit during float on pattern positions only
        if (next_cur.flt && fire_pat[grp_pos] && (choice != fmps_pkg::CHOICE_NONE)) begin
          next_cur.led[choice - 2'h1] = 1'b1;
        end
        if (last) begin
          next_cur.st = fmps_pkg::FMPS_WAIT_RES;
        end
      end
      fmps_pkg::FMPS_WAIT_RES: begin
        if (result_valid) begin
          next_cur.pnum = cur.pnum + 8'h01;
          next_cur.first = 1'b0;
          next_cur.dump_c = nxt_dump;
          next_cur.integ_at = nxt_integ_at;
          next_cur.end_c = (nxt_integ_end > nxt_conn_end) ? nxt_integ_end : nxt_conn_end;
          if (cur.pnum + 8'h01 == cur.pulses) begin
            next_cur.st = fmps_pkg::FMPS_WRITE;
          end else begin
            next_cur.st = fmps_pkg::FMPS_RUN;
          end
        end
      end
      fmps_pkg::FMPS_WRITE: begin
        // single write per slot per sample period, total of all pulses
        next_cur.wr = 1'b1;
        next_cur.wval = acc;
        next_cur.wslot = cur.slot;
        if (!cur.slot) begin
          next_cur.slot = 1'b1;
          next_cur.st = fmps_pkg::FMPS_SETUP;
        end else begin
          next_cur.st = fmps_pkg::FMPS_IDLE;
        end
      end
      default: begin
        next_cur.st = fmps_pkg::FMPS_IDLE;
      end
    endcase
    // busy kept in a flop so the port carries no state decode
    next_cur.bsy = (next_cur.st != fmps_pkg::FMPS_IDLE);
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cur <= '0;
      cur.st <= fmps_pkg::FMPS_IDLE;
      cur.rf <= {fmps_pkg::NREG{fmps_pkg::REG_RESET}};
    end else begin
      cur <= next_cur;
    end
  end

  // outputs straight from state flops
  assign reg_rdata = cur.rdata;
  assign busy = cur.bsy;
  assign precondition_on = cur.pre;
  assign float_on = cur.flt;
  assign connect_on = cur.con;
  assign integrate_on = cur.integ;
  assign led_drive = cur.led;
  assign active_slot = cur.slot;
  assign data_wr = cur.wr;
  assign data_slot = cur.wslot;
  assign data_value = cur.wval;
endmodule

// *** verif/fmps_sequencer_properties.sv ***
// port assertions for the float-mode pulse sequencer
// assumes no register writes while a sample period runs
`timescale 1ns/10ps
module fmps_sequencer_chk #(
  parameter int RW = 14,
  parameter int ACC_W = 27
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // register port
  input wire logic reg_wr,
  input wire logic [fmps_pkg::AW-1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  // sequence
  input wire logic sample_start,
  input wire logic busy,
  input wire logic precondition_on,
  input wire logic float_on,
  input wire logic connect_on,
  input wire logic integrate_on,
  input wire logic [2:0] led_drive,
  input wire logic active_slot,
  input wire logic data_wr,
  input wire logic data_slot,
  input wire logic [ACC_W-1:0] data_value
);
  logic [15:0] sel, cn_a, cn_b, fl_a, fl_b, ch_a, ch_b, iw_a, iw_b;
  logic [11:0] ccnt, pcnt, icnt;
  logic [4:0] conn, pre, iw;
  logic [1:0] ch;
  assign iw = active_slot ? iw_b[15:11] : iw_a[15:11];
  // fields of the slot now running
  assign conn = active_slot ? cn_b[12:8] : cn_a[12:8];
  assign pre = active_slot ? fl_b[12:8] : fl_a[12:8];
  assign ch = active_slot ? ch_b[15:14] : ch_a[15:14];
  // shadow fields; window lengths counted so a miscount shows at the fall
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      {sel, cn_a, cn_b, fl_a, fl_b, ch_a, ch_b, iw_a, iw_b} <= '0;
      ccnt <= 12'h000;
      icnt <= 12'h000;
      pcnt <= 12'h000;
    end else begin
      if (reg_wr) begin
        case (reg_addr)
          7'h14: sel <= reg_wdata;
          7'h30: cn_a <= reg_wdata;
          7'h35: cn_b <= reg_wdata;
          7'h5E: fl_a <= reg_wdata;
          7'h59: fl_b <= reg_wdata;
          7'h3E: ch_a <= reg_wdata;
          7'h3F: ch_b <= reg_wdata;
          7'h39: iw_a <= reg_wdata;
          7'h3B: iw_b <= reg_wdata;
          default: ;
        endcase
      end
      ccnt <= connect_on ? ccnt + 12'h001 : 12'h000;
      pcnt <= precondition_on ? pcnt + 12'h001 : 12'h000;
      icnt <= integrate_on ? icnt + 12'h001 : 12'h000;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  AST_PRECON_LEN: assert property ($fell(precondition_on) |-> pcnt == 12'(pre) * 12'h032)
    else $error("precondition window length wrong");
  AST_CONN_LEN: assert property ($fell(connect_on) |-> ccnt == 12'(conn) * 12'h032)
    else $error("connect window length wrong");
  AST_INTEG_LEN: assert property ($fell(integrate_on) |-> icnt == 12'(iw) * 12'h032)
    else $error("integration window length wrong");
  AST_CONN_FLOAT: assert property (connect_on |-> !float_on)
    else $error("float and connect overlap");
  AST_LED_FLOAT: assert property (led_drive != 3'h0 |-> float_on)
    else $error("led driven outside float");
  AST_LED_CODE: assert property (led_drive != 3'h0 |->
    ch != 2'h0 && led_drive == 3'h1 << (ch - 2'h1))
    else $error("wrong led driven");
  AST_START_BUSY: assert property (sample_start && !busy |-> ##[1:2] busy)
    else $error("start not taken");
  AST_WR_ONE: assert property (data_wr |=> !data_wr)
    else $error("data write longer than one cycle");
  AST_HOLD: assert property (!data_wr |-> $stable(data_value) && $stable(data_slot))
    else $error("data changed without write");
  AST_WR_SEL: assert property (data_wr |-> (data_slot ? sel[3:2] : sel[1:0]) == 2'h0)
    else $error("write from slot not in float mode");
  AST_WR_FLTEN: assert property (data_wr |->
    (data_slot ? fl_b[14:13] : fl_a[14:13]) == 2'h3)
    else $error("write from slot without float enable");
  COV_WR_A: cover property (data_wr && !data_slot);
  COV_WR_B: cover property (data_wr && data_slot);
  COV_LED: cover property (led_drive != 3'h0);
endmodule
bind fmps_sequencer fmps_sequencer_chk #(.RW(RW), .ACC_W(ACC_W)) u_chk (.mclk, .rst,
  .reg_wr, .reg_addr, .reg_wdata, .sample_start, .busy, .precondition_on, .float_on,
  .connect_on, .integrate_on, .led_drive, .active_slot, .data_wr, .data_slot, .data_value);

// *** verif/fmps_frontend_model.sv ***
// photodiode, led and integrator path seen by the sequencer
// assumes one result is wanted after each connect/integrate window ends
`timescale 1ns/10ps
module fmps_frontend_model (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // timing from the sequencer
  input wire logic float_on,
  input wire logic connect_on,
  input wire logic integrate_on,
  input wire logic [2:0] led_drive,
  // light levels and answer speed
  input wire logic [13:0] amb,
  input wire logic [13:0] amp,
  input wire logic slow,
  // pulse result
  output logic result_valid,
  output logic [13:0] result
);
  logic lit, win_q, pend;
  logic [3:0] dly;
  // result = ambient, plus led return only if lit during the float
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      {lit, win_q, pend, result_valid} <= '0;
      dly <= 4'h0;
      result <= 14'h0000;
    end else begin
      win_q <= connect_on | integrate_on;
      result_valid <= 1'b0;
      result <= ~result; // not held outside the valid cycle
      if (float_on && led_drive != 3'h0) lit <= 1'b1;
      if (win_q && !(connect_on | integrate_on)) begin
        pend <= 1'b1;
        dly <= slow ? 4'h9 : 4'h0;
      end else if (pend && dly != 4'h0) begin
        dly <= dly - 4'h1;
      end else if (pend) begin
        pend <= 1'b0;
        result_valid <= 1'b1;
        result <= amb + (lit ? amp : 14'h0000);
        lit <= 1'b0;
      end
    end
  end
endmodule

// *** verif/test_float_mode_pulse_sequencer.sv ***
// self-checking bench for the float-mode pulse sequencer
// assumes the front-end model answers every pulse window
`timescale 1ns/10ps
module test_float_mode_pulse_sequencer;
  logic mclk, rst, reg_wr, reg_rd, sample_start, result_valid, busy, data_wr, data_slot;
  logic pre_on, flt_on, con_on, int_on, act, slow;
  logic [6:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, d;
  logic [2:0] led_drive;
  logic [13:0] result, amb, amp;
  logic [26:0] data_value;
  logic [27:0] exp_q[$];
  logic [31:0] seed;
  logic [7:0] n[2];
  logic [3:0] fire[2];
  logic [1:0] m12[2], m34[2], ch[2], md[2];
  int error_cnt, cmp_count, cyc;
  fmps_sequencer dut (.mclk, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .sample_start, .busy, .precondition_on(pre_on), .float_on(flt_on), .connect_on(con_on),
    .integrate_on(int_on), .led_drive, .active_slot(act), .result_valid, .result,
    .data_wr, .data_slot, .data_value);
  fmps_frontend_model fe (.mclk, .rst, .float_on(flt_on), .connect_on(con_on),
    .integrate_on(int_on), .led_drive, .amb, .amp, .slow, .result_valid, .result);
  // 50 MHz
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    cmp_count++;
    if (s !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  // register read-back compare
  task automatic chk_reg(input logic [15:0] e, input logic [15:0] s);
    chk("register read", 32'(e), 32'(s));
  endtask
  task automatic wr(input logic [6:0] a, input logic [15:0] v);
    @(posedge mclk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, v};
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [6:0] a, input logic [15:0] e);
    @(posedge mclk);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    chk_reg(e, reg_rdata);
  endtask
  // signed sum over all pulses, four-position pattern repeating
  function automatic logic [26:0] expv(input int s);
    logic [26:0] acc;
    logic [13:0] v;
    logic [1:0] p;
    logic sub;
    acc = '0;
    for (int k = 0; k < n[s]; k++) begin
      p = 2'(k);
      sub = p[1] ? m34[s][~p[0]] : m12[s][~p[0]];
      v = amb + ((fire[s][p] && ch[s] != 2'h0) ? amp : 14'h0000);
      acc = sub ? acc - 27'(v) : acc + 27'(v);
    end
    return acc;
  endfunction
  // precon 1us, dump 4us, connect 2us, period 5us so float 1 lasts 3us and later floats 5us
  task automatic setup();
    wr(7'h14, {12'h000, md[1] == 2'h1 ? 2'h1 : 2'h0, md[0] == 2'h1 ? 2'h2 : 2'h0});
    wr(7'h30, 16'h0204);
    wr(7'h35, 16'h0204);
    wr(7'h31, {n[0], 8'h05});
    wr(7'h36, {n[1], 8'h05});
    wr(7'h37, 16'h0000);
    wr(7'h39, 16'h1860);
    wr(7'h3B, 16'h1860);
    wr(7'h3E, {ch[0], 14'h0000});
    wr(7'h3F, {ch[1], 14'h0000});
    wr(7'h58, {4'h0, m34[1], m34[0], 1'b0, m12[1], 2'h0, m12[0], 1'b0});
    wr(7'h5A, {fire[1], fire[0], 8'h00});
    wr(7'h5E, {1'b0, md[0] == 2'h2 ? 2'h2 : 2'h3, 5'h01, 8'h00});
    wr(7'h59, {1'b0, md[1] == 2'h2 ? 2'h2 : 2'h3, 5'h01, 8'h00});
    wr(7'h43, 16'hAE65);
    wr(7'h45, 16'hAE65);
  endtask
  task automatic run_sample();
    setup();
    for (int s = 0; s < 2; s++)
      if (md[s] == 2'h0 && n[s] != 8'h00) exp_q.push_back({s[0], expv(s)});
    @(posedge mclk) sample_start <= 1'b1;
    @(posedge mclk) sample_start <= 1'b0;
    repeat (200) @(posedge mclk);
    sample_start <= 1'b1; // second start must be ignored while busy; with both slots skipped the sequencer is idle again and takes it
    @(posedge mclk) sample_start <= 1'b0;
    // busy looked at off the edge that launches it
    @(negedge mclk);
    while (busy !== 1'b0) @(negedge mclk);
    repeat (4) @(posedge mclk);
    chk("pending writes", 0, exp_q.size());
  endtask
  // each write is matched against the oldest prediction
  always @(negedge mclk) begin
    if (data_wr === 1'b1) begin
      if (exp_q.size() == 0) chk("unexpected write", 0, 1);
      else chk("data write", exp_q.pop_front(), {data_slot, data_value});
    end
  end
  // hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 90000) begin
      error_cnt++;
      complete_run();
    end
  end
  task complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    {rst, slow} = 2'b10;
    {reg_wr, reg_rd, sample_start, reg_addr, reg_wdata, amb, amp} = '0;
    {seed, error_cnt, cmp_count, cyc} = {32'h0000_0037, 96'h0};
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    for (int i = 0; i < 16; i++) rd(fmps_pkg::REG_ADDRS[i], 16'h0000);
    for (int i = 0; i < 16; i++) begin
      d = 16'(rnd());
      wr(fmps_pkg::REG_ADDRS[i], d);
      rd(fmps_pkg::REG_ADDRS[i], d);
    end
    wr(7'h20, 16'hFFFF);
    rd(7'h20, 16'h0000);
    // recommended group, then counts, skipped slots and random patterns
    for (int i = 0; i < 6; i++) begin
      for (int s = 0; s < 2; s++) begin
        {md[s], n[s], fire[s], m12[s], m34[s], ch[s]} = {2'h0, 8'h04, 4'h6, 2'h2, 2'h1, 2'(s + 1)};
        if (i > 1) begin
          {fire[s], m12[s], m34[s], ch[s]} = 10'(rnd());
          n[s] = 8'(2 * (rnd() % 4 + 1));
        end
      end
      if (i == 1) {n[0], n[1], ch[0]} = {8'h08, 8'h02, 2'h3};
      if (i == 2) md[0] = 2'h1;
      if (i == 3) {md[0], n[1]} = {2'h2, 8'h00};
      amb <= 14'(rnd() % 4096);
      amp <= 14'(rnd() % 4096);
      slow <= i[0];
      run_sample();
    end
    complete_run();
  end
endmodule
